// ==== rtl/wirtc_top.sv ====
// Wakeup interval timer and real-time clock with register port
`timescale 1ns/1ps
`default_nettype none
`include "wirtc_params.svh"
module wirtc_top #(
   parameter int unsigned TICK_CYCLES = `WIRTC_TICK_CYC
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output var  logic [7:0]  rdata,
   input  wire logic        pd_mode,
   input  wire logic        tic_int_en,
   input  wire logic        hw_rst_req,
   output var  logic        irq,
   output var  logic        int_req,
   output var  logic        wake_req,
   output var  logic [15:0] wake_vector
);
   import wirtc_pkg::*;

   wirtc_state_t q;
   wirtc_state_t d;
   logic         tick;
   logic         frac_ovf;
   logic         sec_ovf;
   logic         min_ovf;
   logic         step;
   logic         match_ev;
   logic         wake_now;
   logic         pd;
   logic         ien;
   logic         rst_req;
   logic [7:0]   icnt_nxt;
   logic [1:0]   w1c;

   // Address compare, shared by write and read decode
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      reg_hit = (a == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Timebase divider; mclk stands for the always-on clock
   wirtc_prescale #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_prescale (
      .mclk   (mclk),
      .arst_n (arst_n),
      .run    (q.run),
      .tick   (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      d = q;
      // Two-stage synchronisers for the core-side levels
      d.sync1 = {hw_rst_req, tic_int_en, pd_mode};
      d.sync2 = q.sync1;
      pd      = q.sync2[`WIRTC_S_PD];
      ien     = q.sync2[`WIRTC_S_IEN];
      rst_req = q.sync2[`WIRTC_S_RST];

      // Time chain; power-down does not gate it
      frac_ovf = q.run && tick && (q.frac == `WIRTC_FRAC_MAX);
      sec_ovf  = frac_ovf && (q.sec == `WIRTC_SEC_MAX);
      min_ovf  = sec_ovf && (q.min == `WIRTC_MIN_MAX);
      if (q.run && tick)
      begin
         d.frac = frac_ovf ? 7'h00 : q.frac + 7'h01;
         if (frac_ovf)
         begin
            d.sec = sec_ovf ? 6'h00 : q.sec + 6'h01;
         end
         if (sec_ovf)
         begin
            d.min = min_ovf ? 6'h00 : q.min + 6'h01;
         end
         if (min_ovf)
         begin
            // No day count; software keeps the calendar
            d.h_field_reg = q.h_field_reg + 8'h01;
         end
      end

      // Step source for the interval counter
      case (q.tb_sel)
         WIRTC_TB_FRAC: step = q.run && tick;
         WIRTC_TB_SEC:  step = frac_ovf;
         WIRTC_TB_MIN:  step = sec_ovf;
         WIRTC_TB_H_FIELD_REG: step = min_ovf;
         default:       step = 1'b0;
      endcase

      // Register writes
      w1c = 2'h0;
      if (wr_en)
      begin
         if (reg_hit(addr, `WIRTC_OFF_CTRL))
         begin
            d.run      = wdata[`WIRTC_B_RUN];
            d.cnt_en   = wdata[`WIRTC_B_CEN];
            d.flag     = wdata[`WIRTC_B_FLAG];
            d.one_shot = wdata[`WIRTC_B_ONESHOT];
            d.tb_sel   = wirtc_tb_t'(wdata[`WIRTC_B_TBSEL_HI:`WIRTC_B_TBSEL_LO]);
            // Stopping the timebase zeroes the time
            if (q.run && !wdata[`WIRTC_B_RUN])
            begin
               d.frac = 7'h00;
               d.sec  = 6'h00;
               d.min  = 6'h00;
               d.h_field_reg = 8'h00;
            end
         end
         else if (reg_hit(addr, `WIRTC_OFF_FRAC))
         begin
            if (!q.run)
            begin
               d.frac = wdata[6:0];
            end
         end
         else if (reg_hit(addr, `WIRTC_OFF_SEC))
         begin
            if (!q.run)
            begin
               d.sec = wdata[5:0];
            end
         end
         else if (reg_hit(addr, `WIRTC_OFF_MIN))
         begin
            if (!q.run)
            begin
               d.min = wdata[5:0];
            end
         end
         else if (reg_hit(addr, `WIRTC_OFF_H_FIELD_REG))
         begin
            if (!q.run)
            begin
               d.h_field_reg = wdata;
            end
         end
         else if (reg_hit(addr, `WIRTC_OFF_TARGET))
         begin
            d.target = wdata;
         end
         else if (reg_hit(addr, `WIRTC_OFF_ISTS))
         begin
            w1c = wdata[1:0];
         end
         else if (reg_hit(addr, `WIRTC_OFF_IMASK))
         begin
            d.imask = wdata[1:0];
         end
      end

      // Interval counter; match on the step that reaches the target
      icnt_nxt = q.icnt + 8'h01;
      match_ev = q.cnt_en && step && (icnt_nxt == q.target);
      if (!q.cnt_en)
      begin
         d.icnt = 8'h00;
      end
      else if (step)
      begin
         d.icnt = match_ev ? 8'h00 : icnt_nxt;
      end
      // Set wins over a software clear in the same cycle
      if (match_ev)
      begin
         d.flag = 1'b1;
         if (q.one_shot)
         begin
            d.cnt_en = 1'b0;
         end
      end

      // Sticky status, write one to clear, set wins
      wake_now = pd && ien && q.flag;
      d.ists[`WIRTC_EV_MATCH] = (q.ists[`WIRTC_EV_MATCH] & ~w1c[`WIRTC_EV_MATCH]) | match_ev;
      d.ists[`WIRTC_EV_WAKE]  = (q.ists[`WIRTC_EV_WAKE] & ~w1c[`WIRTC_EV_WAKE]) | (wake_now & ~q.wake);

      // Hardware or watchdog reset keeps a running clock
      if (rst_req)
      begin
         d.cnt_en   = 1'b0;
         d.one_shot = 1'b0;
         d.flag     = 1'b0;
         d.tb_sel   = WIRTC_TB_FRAC;
         d.target   = 8'h00;
         d.icnt     = 8'h00;
         d.ists     = 2'h0;
         d.imask    = 2'h0;
         if (!q.run)
         begin
            d.run  = 1'b0;
            d.frac = 7'h00;
            d.sec  = 6'h00;
            d.min  = 6'h00;
            d.h_field_reg = 8'h00;
         end
      end

      // Outputs, registered
      d.int_req = q.flag && ien;
      d.wake    = wake_now;
      d.vec     = wake_now ? `WIRTC_VECTOR : 16'h0000;
      d.irq     = |(q.ists & q.imask);

      // Read data stand one cycle after the strobe only
      d.rdata = 8'h00;
      if (rd_en)
      begin
         if (reg_hit(addr, `WIRTC_OFF_CTRL))
         begin
            d.rdata = {2'h0, q.tb_sel, q.one_shot, q.flag, q.cnt_en, q.run};
         end
         else if (reg_hit(addr, `WIRTC_OFF_FRAC))
         begin
            d.rdata = {1'b0, q.frac};
         end
         else if (reg_hit(addr, `WIRTC_OFF_SEC))
         begin
            d.rdata = {2'h0, q.sec};
         end
         else if (reg_hit(addr, `WIRTC_OFF_MIN))
         begin
            d.rdata = {2'h0, q.min};
         end
         else if (reg_hit(addr, `WIRTC_OFF_H_FIELD_REG))
         begin
            d.rdata = q.h_field_reg;
         end
         else if (reg_hit(addr, `WIRTC_OFF_TARGET))
         begin
            d.rdata = q.target;
         end
         else if (reg_hit(addr, `WIRTC_OFF_ICNT))
         begin
            d.rdata = q.icnt;
         end
         else if (reg_hit(addr, `WIRTC_OFF_ISTS))
         begin
            d.rdata = {6'h00, q.ists};
         end
         else if (reg_hit(addr, `WIRTC_OFF_IMASK))
         begin
            d.rdata = {6'h00, q.imask};
         end
      end
   end

   // Power-on reset clears everything, run enable included
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign rdata       = q.rdata;
   assign irq         = q.irq;
   assign int_req     = q.int_req;
   assign wake_req    = q.wake;
   assign wake_vector = q.vec;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   sequence s_frac_wrap;
      q.run && tick && (q.frac == `WIRTC_FRAC_MAX);
   endsequence

   sequence s_sec_wrap;
      s_frac_wrap and (q.sec == `WIRTC_SEC_MAX);
   endsequence

   sequence s_wake_cause;
      pd && ien && q.flag;
   endsequence

   // Time chain checks
   frac_wrap_a: assert property (s_frac_wrap |=> q.frac == 7'h00)
      else $error("fraction did not wrap after 127");
   // A write that stops the timebase zeroes the time even on a tick
   frac_step_a: assert property (q.run && tick && q.frac != `WIRTC_FRAC_MAX && !rst_req
      && !(wr_en && reg_hit(addr, `WIRTC_OFF_CTRL) && !wdata[`WIRTC_B_RUN])
      |=> q.frac == $past(q.frac) + 7'h01)
      else $error("fraction did not step on tick");
   sec_wrap_a: assert property (s_sec_wrap ##0 !wr_en |=> q.sec == 6'h00 && q.min != $past(q.min))
      else $error("seconds did not wrap into minutes");
   h_field_reg_step_a: assert property (min_ovf && !rst_req && !wr_en
      |=> q.h_field_reg == $past(q.h_field_reg) + 8'h01)
      else $error("hours did not step on minute wrap");
   time_write_a: assert property (wr_en && reg_hit(addr, `WIRTC_OFF_SEC) && !q.run && !rst_req
      |=> q.sec == $past(wdata[5:0]))
      else $error("seconds write lost while stopped");
   time_lock_a: assert property (wr_en && reg_hit(addr, `WIRTC_OFF_H_FIELD_REG) && q.run && !min_ovf
      |=> $stable(q.h_field_reg))
      else $error("hours written while running");
   keep_time_a: assert property (rst_req && q.run && !wr_en |=> q.run)
      else $error("reset dropped a running clock");
   clear_time_a: assert property (rst_req && !q.run
      |=> !q.run && q.frac == 7'h00 && q.sec == 6'h00 && q.min == 6'h00 && q.h_field_reg == 8'h00)
      else $error("idle reset left time set");
   // Interval counter and flag checks
   icnt_clear_a: assert property (!q.cnt_en |=> q.icnt == 8'h00)
      else $error("interval counter not zero while disabled");
   icnt_step_a: assert property (q.cnt_en && step && !match_ev && !rst_req
      |=> q.icnt == $past(q.icnt) + 8'h01)
      else $error("interval counter missed a step");
   // Request follows the enable as it stood one cycle earlier
   match_flag_a: assert property (match_ev && !rst_req |=> q.flag ##1 (int_req == $past(ien)))
      else $error("match did not set flag and request");
   int_clear_a: assert property (!q.flag |=> !int_req)
      else $error("request without match flag");
   one_shot_a: assert property (match_ev && q.one_shot |=> !q.cnt_en ##1 q.icnt == 8'h00)
      else $error("one-shot timeout left counter enabled");
   reload_a: assert property (match_ev && !q.one_shot && !rst_req && !wr_en |=> q.cnt_en && q.icnt == 8'h00)
      else $error("periodic timeout did not reload");
   // Output and status checks
   wake_vec_a: assert property (s_wake_cause |=> wake_req && wake_vector == 16'h0053)
      else $error("wake without vector 0053");
   wake_idle_a: assert property (!pd |=> !wake_req && wake_vector == 16'h0000)
      else $error("wake raised outside power-down");
   irq_level_a: assert property (|(q.ists & q.imask) |=> irq)
      else $error("unmasked status did not raise irq");
   ists_sticky_a: assert property (q.ists[`WIRTC_EV_MATCH] && !rst_req
      && !(wr_en && reg_hit(addr, `WIRTC_OFF_ISTS) && wdata[`WIRTC_EV_MATCH])
      |=> q.ists[`WIRTC_EV_MATCH])
      else $error("match status lost without a clear");
endmodule
`default_nettype wire

// ==== shared/wirtc_params.svh ====
// Constants for the wakeup interval timer and real-time clock
// Summary of operation
// - Timeouts span 1/128 second to 255 hours
// - Timer runs from always-on clock, ignores power-down
// - Hardware counts fraction, seconds, minutes, hours only
// - Time registers writable only while run enable low
// - Hardware reset keeps time while running
// - Power-on or idle reset clears time, enable
// - Each increment of selected register steps interval counter
// - Counter equals target: set flag, request interrupt
// - Flag wakes power-down core to vector 0053h
// - Select codes: fraction, seconds, minutes, hours
// - One-shot clears enable; else counter reloads
// - Clearing count enable stops and zeroes counter
// - Fraction counts 0..127, carries into seconds
`ifndef WIRTC_PARAMS_SVH
`define WIRTC_PARAMS_SVH

// Clock and timebase
`define WIRTC_CLK_NS        10
`define WIRTC_TICK_NS       7812500
`define WIRTC_TICK_CYC      (`WIRTC_TICK_NS / `WIRTC_CLK_NS)

// Register offsets
`define WIRTC_OFF_CTRL      8'ha1
`define WIRTC_OFF_FRAC      8'ha2
`define WIRTC_OFF_SEC       8'ha3
`define WIRTC_OFF_MIN       8'ha4
`define WIRTC_OFF_H_FIELD_REG      8'ha5
`define WIRTC_OFF_TARGET    8'ha6
`define WIRTC_OFF_ICNT      8'ha7
`define WIRTC_OFF_ISTS      8'ha8
`define WIRTC_OFF_IMASK     8'ha9

// Control field positions
`define WIRTC_B_RUN         0
`define WIRTC_B_CEN         1
`define WIRTC_B_FLAG        2
`define WIRTC_B_ONESHOT     3
`define WIRTC_B_TBSEL_LO    4
`define WIRTC_B_TBSEL_HI    5

// Status and synchroniser bit positions
`define WIRTC_EV_MATCH      0
`define WIRTC_EV_WAKE       1
`define WIRTC_S_PD          0
`define WIRTC_S_IEN         1
`define WIRTC_S_RST         2

// Counter limits and vector
`define WIRTC_FRAC_MAX      7'h7f
`define WIRTC_SEC_MAX       6'h3b
`define WIRTC_MIN_MAX       6'h3b
`define WIRTC_VECTOR        16'h0053

`endif

// ==== shared/wirtc_pkg.sv ====
// Types for the wakeup interval timer and real-time clock
package wirtc_pkg;

   // Interval step source
   typedef enum logic [1:0] {
      WIRTC_TB_FRAC = 2'h0,
      WIRTC_TB_SEC  = 2'h1,
      WIRTC_TB_MIN  = 2'h2,
      WIRTC_TB_H_FIELD_REG = 2'h3
   } wirtc_tb_t;

   // Whole state of the top module
   typedef struct packed {
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic        run;
      logic        cnt_en;
      logic        one_shot;
      logic        flag;
      wirtc_tb_t   tb_sel;
      logic [6:0]  frac;
      logic [5:0]  sec;
      logic [5:0]  min;
      logic [7:0]  h_field_reg;
      logic [7:0]  target;
      logic [7:0]  icnt;
      logic [1:0]  ists;
      logic [1:0]  imask;
      logic [7:0]  rdata;
      logic        irq;
      logic        int_req;
      logic        wake;
      logic [15:0] vec;
   } wirtc_state_t;

   // State of the timebase divider
   typedef struct packed {
      logic [19:0] cnt;
      logic        tick;
   } wirtc_div_t;

endpackage

// ==== rtl/wirtc_prescale.sv ====
// Divider making the 1/128 second tick enable
`timescale 1ns/1ps
`default_nettype none
`include "wirtc_params.svh"
module wirtc_prescale #(
   parameter int unsigned TICK_CYCLES = `WIRTC_TICK_CYC
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic run,
   output var  logic tick
);
   import wirtc_pkg::*;

   wirtc_div_t q;
   wirtc_div_t d;

   ////////////////////////////////////////////////////////////////////////
   // Divider held cleared while the timebase is stopped
   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (!run)
      begin
         d.cnt = 20'h00000;
      end
      else if (q.cnt == 20'(TICK_CYCLES - 1))
      begin
         d.cnt  = 20'h00000;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 20'h00001;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the wakeup interval timer and clock
`timescale 1ns/1ps
`default_nettype none
`include "wirtc_params.svh"
module tb_top;
   logic        mclk;
   logic        arst_n;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rdata;
   logic        pd_mode;
   logic        tic_int_en;
   logic        hw_rst_req;
   logic        irq;
   logic        int_req;
   logic        wake_req;
   logic [15:0] wake_vector;
   int          mismatches = 0;
   int          total_checks = 0;
   int          cycles = 0;

   // Short tick keeps every cascade within a few hundred cycles
   wirtc_top #(.TICK_CYCLES(4)) dut (
      .mclk        (mclk),
      .arst_n      (arst_n),
      .addr        (addr),
      .wdata       (wdata),
      .wr_en       (wr_en),
      .rd_en       (rd_en),
      .rdata       (rdata),
      .pd_mode     (pd_mode),
      .tic_int_en  (tic_int_en),
      .hw_rst_req  (hw_rst_req),
      .irq         (irq),
      .int_req     (int_req),
      .wake_req    (wake_req),
      .wake_vector (wake_vector)
   );

   // 100 MHz clock
   always #5 mclk = ~mclk;

   // Hang guard, well above the expected run length
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Report and bus tasks
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(name, {8'h00, d}, {8'h00, exp});
   endtask

   // Bounded poll; a read every two cycles cannot miss a four-cycle value
   task automatic poll(input logic [7:0] a, input logic [7:0] val);
      logic [7:0] d;
      d = ~val;
      for (int i = 0; i < 400 && d !== val; i++)
         rd(a, d);
      check("poll", {8'h00, d}, {8'h00, val});
   endtask

   task automatic hw_pulse;
      @(posedge mclk);
      hw_rst_req <= 1'b1;
      repeat (4) @(posedge mclk);
      hw_rst_req <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      rdc("ctrl", `WIRTC_OFF_CTRL, 8'h00);
      rdc("frac", `WIRTC_OFF_FRAC, 8'h00);
      rdc("h_field_reg", `WIRTC_OFF_H_FIELD_REG, 8'h00);
      rdc("icnt", `WIRTC_OFF_ICNT, 8'h00);
      rdc("unmapped", 8'h10, 8'h00);
   endtask

   // Full cascade from 127/59/59 into the hours
   task automatic t_time;
      wr(`WIRTC_OFF_FRAC, 8'h7f);
      wr(`WIRTC_OFF_SEC, 8'h3b);
      wr(`WIRTC_OFF_MIN, 8'h3b);
      wr(`WIRTC_OFF_H_FIELD_REG, 8'h05);
      rdc("sec load", `WIRTC_OFF_SEC, 8'h3b);
      wr(`WIRTC_OFF_CTRL, 8'h01);
      poll(`WIRTC_OFF_FRAC, 8'h00);
      rdc("sec wrap", `WIRTC_OFF_SEC, 8'h00);
      rdc("min wrap", `WIRTC_OFF_MIN, 8'h00);
      wr(`WIRTC_OFF_H_FIELD_REG, 8'h20);
      rdc("h_field_reg", `WIRTC_OFF_H_FIELD_REG, 8'h06);
   endtask

   // Warm reset keeps a running clock, clears a stopped one
   task automatic t_keep;
      hw_pulse();
      rdc("ctrl kept", `WIRTC_OFF_CTRL, 8'h01);
      rdc("h_field_reg kept", `WIRTC_OFF_H_FIELD_REG, 8'h06);
      wr(`WIRTC_OFF_CTRL, 8'h00);
      wr(`WIRTC_OFF_H_FIELD_REG, 8'h09);
      hw_pulse();
      rdc("h_field_reg idle", `WIRTC_OFF_H_FIELD_REG, 8'h00);
      wr(`WIRTC_OFF_H_FIELD_REG, 8'h07);
      wr(`WIRTC_OFF_CTRL, 8'h01);
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      rdc("ctrl power", `WIRTC_OFF_CTRL, 8'h00);
      rdc("h_field_reg power", `WIRTC_OFF_H_FIELD_REG, 8'h00);
   endtask

   // Periodic match on the fraction step, interrupt and wake paths
   task automatic t_periodic;
      wr(`WIRTC_OFF_IMASK, 8'h01);
      wr(`WIRTC_OFF_TARGET, 8'h02);
      wr(`WIRTC_OFF_CTRL, 8'h03);
      poll(`WIRTC_OFF_ISTS, 8'h01);
      rdc("ctrl reload", `WIRTC_OFF_CTRL, 8'h07);
      repeat (2) @(posedge mclk);
      check("irq", {15'h0, irq}, 16'h0001);
      tic_int_en <= 1'b1;
      repeat (4) @(posedge mclk);
      check("int_req", {15'h0, int_req}, 16'h0001);
      pd_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      check("wake", {15'h0, wake_req}, 16'h0001);
      check("vector", wake_vector, 16'h0053);
      pd_mode    <= 1'b0;
      tic_int_en <= 1'b0;
      wr(`WIRTC_OFF_CTRL, 8'h01);
      rdc("icnt clear", `WIRTC_OFF_ICNT, 8'h00);
      wr(`WIRTC_OFF_ISTS, 8'h03);
      rdc("ists", `WIRTC_OFF_ISTS, 8'h00);
      repeat (2) @(posedge mclk);
      check("irq off", {15'h0, irq}, 16'h0000);
   endtask

   // Single interval drops the count enable; masked, so no irq
   task automatic t_oneshot;
      wr(`WIRTC_OFF_IMASK, 8'h00);
      wr(`WIRTC_OFF_TARGET, 8'h01);
      wr(`WIRTC_OFF_CTRL, 8'h0b);
      poll(`WIRTC_OFF_ISTS, 8'h01);
      rdc("ctrl single", `WIRTC_OFF_CTRL, 8'h0d);
      check("irq masked", {15'h0, irq}, 16'h0000);
      wr(`WIRTC_OFF_ISTS, 8'h01);
   endtask

   // Each slower step source moves the counter once per cascade only
   task automatic t_tbsel;
      logic [1:0] k;
      for (int i = 1; i < 4; i++)
      begin
         k = i[1:0];
         wr(`WIRTC_OFF_CTRL, 8'h00);
         wr(`WIRTC_OFF_FRAC, 8'h7f);
         wr(`WIRTC_OFF_SEC, (i > 1) ? 8'h3b : 8'h00);
         wr(`WIRTC_OFF_MIN, (i > 2) ? 8'h3b : 8'h00);
         wr(`WIRTC_OFF_TARGET, 8'h02);
         wr(`WIRTC_OFF_CTRL, {2'b00, k, 4'b0011});
         poll(`WIRTC_OFF_FRAC, 8'h00);
         rdc("icnt step", `WIRTC_OFF_ICNT, 8'h01);
         poll(`WIRTC_OFF_FRAC, 8'h03);
         rdc("icnt hold", `WIRTC_OFF_ICNT, 8'h01);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      mclk       = 1'b0;
      arst_n     = 1'b0;
      addr       = 8'h00;
      wdata      = 8'h00;
      wr_en      = 1'b0;
      rd_en      = 1'b0;
      pd_mode    = 1'b0;
      tic_int_en = 1'b0;
      hw_rst_req = 1'b0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset();
      t_time();
      t_keep();
      t_periodic();
      t_oneshot();
      t_tbsel();
      complete_run();
   end
endmodule
`default_nettype wire
